// file: rtl/tws_eeprom_slave.sv
`timescale 1ns/1ps

// Summary of operation
// - Input bits latched on clock rise; output bit changes after clock fall.
// - Data line is open drain: only pulled low or released.
// - Protect input high blocks all programming; reads unaffected.
// - Array is 128 pages of 16 bytes, 11 bit word address.
// - Data falling while clock high is a start; commands begin with it.
// - Stop ends read into standby; after write, standby once programmed.
// - Eight bit words; device pulls data low on 9th clock as acknowledge.
// - Standby after power-up, after read stop, after programming ends.
// - First word after start must carry type code 1010.
// - Match acknowledges after 8th bit; mismatch gives no ack, standby.
// - Chip select inputs ignored; address bits 5 to 7 need no match.
// - Eighth device word bit: one means read, zero means write.
// - Byte write: address, one data byte, each acked; stop starts cycle.
// - During the write cycle all bus inputs are ignored.
// - Write cycle lasts at most 5 ms; slower grade up to 8 ms.
// - Page write sends up to 15 more bytes, each acked, then stop.
// - Page write increments only low address bits; wraps within page.
// - Polling: no ack while programming, ack once finished.
// - Address counter holds last accessed address plus one.
// - Current read: ack, send byte, bump counter; nack and stop end it.
// - Master ack makes device send next byte from bumped counter.
// - Read counter wraps from highest address to zero.
// - Repeated start after address-only write abandons pending write.
module tws_eeprom_slave #(
	parameter int PROG_CYC = tws_pkg::PROG_CYCLES
)(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic serial_clk,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	input  wire logic write_protect,
	input  wire logic chip_select_bit_two,
	input  wire logic chip_select_bit_one,
	input  wire logic chip_select_bit_zero,
	output logic      standby,
	output logic      prog_busy
);

	localparam int AW = tws_pkg::ADDR_W;
	localparam int DW = tws_pkg::DATA_W;
	localparam int PW = tws_pkg::PAGE_W;
	localparam int TW = $clog2(PROG_CYC + 1);
	localparam int FW = tws_pkg::FILT_W;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [DW-1:0]         link_shift_r;
	tws_pkg::tws_lines_t   raw_lines;
	tws_pkg::tws_lines_t   filt_lines;
	tws_pkg::tws_lines_t   prev_lines_r;
	tws_pkg::tws_events_t  ev;
	logic                  wp_meta_r;
	logic                  wp_sync_r;
	tws_pkg::tws_state_t   state_r;
	logic [3:0]            bit_cnt_r;
	logic                  ack_r;
	logic [AW-1:0]         addr_r;
	logic [DW-1:0]         page_buf_r [tws_pkg::PAGE_BYTES];
	logic [tws_pkg::PAGE_BYTES-1:0] page_vld_r;
	logic [TW-1:0]         timer_r;
	logic                  prog_done;
	logic                  prog_wr;
	logic [DW-1:0]         mem_r [tws_pkg::MEM_BYTES];
	logic [DW-1:0]         tx_r;
	logic                  byte_in;
	logic                  ack_slot;
	logic                  rd_load;
	logic                  dev_match;

	// Chip select pins have no meaning at this density
	logic                  cs_unused;
	assign cs_unused = chip_select_bit_two ^ chip_select_bit_one
		^ chip_select_bit_zero;

	// ----------------------------------------------------------------
	// Link clock domain: serial bits latched on clock rise
	// ----------------------------------------------------------------
	// Word stays stable from one rise to the next; the system side
	// reads it only after seeing the filtered rise, so it is settled.
	always_ff @(posedge serial_clk or negedge rst_n)
	begin
		if (!rst_n)
			link_shift_r <= 8'h00;
		else
			link_shift_r <= {link_shift_r[DW-2:0], sda_in};
	end

	// ----------------------------------------------------------------
	// Line synchronisers and glitch filters
	// ----------------------------------------------------------------
	assign raw_lines.scl = serial_clk;
	assign raw_lines.sda = sda_in;

	// Same two-stage sync and spike filter for both lines
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_line
			logic          meta_r;
			logic          sync_r;
			logic          filt_r;
			logic [FW-1:0] cnt_r;

			// Meta stage is read only by the second flop
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_r <= tws_pkg::LINE_IDLE;
					sync_r <= tws_pkg::LINE_IDLE;
				end
				else
				begin
					meta_r <= raw_lines[g];
					sync_r <= meta_r;
				end
			end

			// Level accepted only after it held for the filter span
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					filt_r <= tws_pkg::LINE_IDLE;
					cnt_r  <= '0;
				end
				else if (sync_r == filt_r)
					cnt_r <= '0;
				else if (cnt_r == FW'(tws_pkg::FILT_CYC - 1))
				begin
					filt_r <= sync_r;
					cnt_r  <= '0;
				end
				else
					cnt_r <= cnt_r + FW'(1);
			end

			assign filt_lines[g] = filt_r;
		end
	endgenerate

	// Protect pin is a slow level, two flops suffice
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_meta_r <= 1'b0;
			wp_sync_r <= 1'b0;
		end
		else
		begin
			wp_meta_r <= write_protect;
			wp_sync_r <= wp_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Bus condition detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_lines_r <= '1;
		else
			prev_lines_r <= filt_lines;
	end

	// Data moving under a high clock is a frame marker, not a bit
	always_comb
	begin
		ev.start = prev_lines_r.scl & filt_lines.scl
			& prev_lines_r.sda & ~filt_lines.sda;
		ev.stop  = prev_lines_r.scl & filt_lines.scl
			& ~prev_lines_r.sda & filt_lines.sda;
		ev.rise  = ~prev_lines_r.scl & filt_lines.scl;
		ev.fall  = prev_lines_r.scl & ~filt_lines.scl;
	end

	// Shared decode terms
	assign byte_in   = ev.rise && (bit_cnt_r == tws_pkg::LAST_BIT);
	assign ack_slot  = ev.rise && (bit_cnt_r == tws_pkg::ACK_BIT);
	assign dev_match = (link_shift_r[7:4] == tws_pkg::DEV_CODE);
	// Own ack or master ack both read as low on the 9th rise
	assign rd_load   = ack_slot && (state_r == tws_pkg::ST_RDATA)
		&& !filt_lines.sda;

	// ----------------------------------------------------------------
	// Protocol state
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= tws_pkg::ST_STANDBY;
		else
		begin
			case (state_r)
				tws_pkg::ST_PROG:
				begin
					// Bus is deaf until the cycle ends
					if (prog_done)
						state_r <= tws_pkg::ST_STANDBY;
				end
				default:
				begin
					if (ev.start)
						state_r <= tws_pkg::ST_DEVADDR;
					else if (ev.stop)
					begin
						if (state_r == tws_pkg::ST_WDATA && |page_vld_r
							&& !wp_sync_r)
							state_r <= tws_pkg::ST_PROG;
						else
							state_r <= tws_pkg::ST_STANDBY;
					end
					else if (byte_in && state_r == tws_pkg::ST_DEVADDR)
					begin
						if (!dev_match)
							state_r <= tws_pkg::ST_STANDBY;
						else if (link_shift_r[0])
							state_r <= tws_pkg::ST_RDATA;
						else
							state_r <= tws_pkg::ST_WADDR;
					end
					else if (byte_in && state_r == tws_pkg::ST_WADDR)
						state_r <= tws_pkg::ST_WDATA;
					else if (ack_slot && state_r == tws_pkg::ST_RDATA
						&& filt_lines.sda)
						state_r <= tws_pkg::ST_DONE;
				end
			endcase
		end
	end

	assign standby   = (state_r == tws_pkg::ST_STANDBY);
	assign prog_busy = (state_r == tws_pkg::ST_PROG);

	// ----------------------------------------------------------------
	// Bit position within the nine-clock word
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bit_cnt_r <= 4'h0;
		else if (ev.start)
			bit_cnt_r <= 4'h0;
		else if (ev.rise)
		begin
			if (bit_cnt_r == tws_pkg::ACK_BIT)
				bit_cnt_r <= 4'h0;
			else
				bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Acknowledge decision for the coming 9th clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else if (ev.start || ev.stop || state_r == tws_pkg::ST_PROG)
			ack_r <= 1'b0;
		else if (byte_in)
		begin
			case (state_r)
				tws_pkg::ST_DEVADDR: ack_r <= dev_match;
				tws_pkg::ST_WADDR:   ack_r <= 1'b1;
				tws_pkg::ST_WDATA:   ack_r <= 1'b1;
				default:             ack_r <= 1'b0;
			endcase
		end
		else if (ack_slot)
			ack_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Address counter
	// ----------------------------------------------------------------
	// Kept across frames so a bare read continues where access stopped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			addr_r <= '0;
		else if (byte_in && state_r == tws_pkg::ST_DEVADDR && dev_match
			&& !link_shift_r[0])
			addr_r[AW-1 -: tws_pkg::HI_ADDR_W] <= link_shift_r[3:1];
		else if (byte_in && state_r == tws_pkg::ST_WADDR)
			addr_r[7:0] <= link_shift_r;
		else if (byte_in && state_r == tws_pkg::ST_WDATA)
			addr_r[PW-1:0] <= addr_r[PW-1:0] + 4'h1;
		else if (rd_load)
			addr_r <= addr_r + AW'(1);
	end

	// ----------------------------------------------------------------
	// Page buffer
	// ----------------------------------------------------------------
	// Bytes gather here and only reach the array after the stop,
	// so a repeated start can drop them without touching the array.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			page_vld_r <= '0;
		else if (ev.start && state_r != tws_pkg::ST_PROG)
			page_vld_r <= '0;
		else if (prog_done)
			page_vld_r <= '0;
		else if (byte_in && state_r == tws_pkg::ST_WDATA)
			page_vld_r[addr_r[PW-1:0]] <= 1'b1;
	end

	// Later bytes at the same slot overwrite earlier ones
	always_ff @(posedge clk)
	begin
		if (byte_in && state_r == tws_pkg::ST_WDATA)
			page_buf_r[addr_r[PW-1:0]] <= link_shift_r;
	end

	// ----------------------------------------------------------------
	// Self-timed programming interval
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_r <= '0;
		else if (state_r == tws_pkg::ST_PROG && !prog_done)
			timer_r <= timer_r + TW'(1);
		else
			timer_r <= '0;
	end

	assign prog_done = (state_r == tws_pkg::ST_PROG)
		&& (timer_r == TW'(PROG_CYC - 1));

	// One buffered byte per cycle in the first sixteen cycles
	assign prog_wr = (state_r == tws_pkg::ST_PROG)
		&& (timer_r < TW'(tws_pkg::PAGE_BYTES))
		&& page_vld_r[timer_r[PW-1:0]];

	// ----------------------------------------------------------------
	// Array
	// ----------------------------------------------------------------
	// No reset: contents are only defined once written
	always_ff @(posedge clk)
	begin
		if (prog_wr)
			mem_r[{addr_r[AW-1:PW], timer_r[PW-1:0]}]
				<= page_buf_r[timer_r[PW-1:0]];
	end

	// Read byte fetched on the ack clock, counter bumps in step
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_r <= 8'hff;
		else if (rd_load)
			tx_r <= mem_r[addr_r];
	end

	// ----------------------------------------------------------------
	// Data line drive
	// ----------------------------------------------------------------
	// Only ever pulls low; a one is sent by releasing the line
	assign sda_out = 1'b0;

	// Changes follow the filtered falling edge, so the master sees
	// stable data well before its next rising edge.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sda_oe_n <= 1'b1;
		else if (ev.start || ev.stop || state_r == tws_pkg::ST_PROG
			|| state_r == tws_pkg::ST_STANDBY)
			sda_oe_n <= 1'b1;
		else if (ev.fall)
		begin
			if (bit_cnt_r == tws_pkg::ACK_BIT)
				sda_oe_n <= !ack_r;
			else if (state_r == tws_pkg::ST_RDATA)
				sda_oe_n <= tx_r[3'h7 - bit_cnt_r[2:0]];
			else
				sda_oe_n <= 1'b1;
		end
	end

endmodule

// file: rtl/tws_pkg.sv
package tws_pkg;

	// ----------------------------------------------------------------
	// Array organisation
	// ----------------------------------------------------------------
	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 11;
	localparam int          MEM_BYTES   = 2048;
	localparam int          PAGE_W      = 4;
	localparam int          PAGE_BYTES  = 16;
	localparam int          PAGES       = 128;
	localparam logic [3:0]  DEV_CODE    = 4'ha;    // Device type 1010
	localparam int          HI_ADDR_W   = 3;       // Block bits from dev word

	// ----------------------------------------------------------------
	// Serial framing
	// ----------------------------------------------------------------
	localparam logic [3:0]  LAST_BIT    = 4'h7;    // 8th rising edge
	localparam logic [3:0]  ACK_BIT     = 4'h8;    // 9th rising edge
	localparam logic        LINE_IDLE   = 1'b1;    // Pulled-up bus level

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ     = 40;
	localparam int          CLK_NS      = 25;
	localparam int          NOISE_NS    = 50;      // Spike width to reject
	localparam int          FILT_CYC    = (NOISE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          FILT_W      = $clog2(FILT_CYC + 1);
	localparam int          PROG_TIME_US      = 5000;
	localparam int          PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
	localparam int          SLOW_PROG_TIME_US = 8000;
	localparam int          SLOW_PROG_CYCLES  = SLOW_PROG_TIME_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_DEVADDR,
		ST_WADDR,
		ST_WDATA,
		ST_RDATA,
		ST_DONE,
		ST_PROG
	} tws_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} tws_lines_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} tws_events_t;

endpackage

// file: tb/tws_eeprom_slave_monitor.sv
`timescale 1ns/1ps

// ----------
// Port checker
// ----------
module tws_eeprom_slave_monitor #(
	parameter int PROG_CYC = 64
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serial_clk,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic write_protect,
	input wire logic chip_select_bit_two,
	input wire logic chip_select_bit_one,
	input wire logic chip_select_bit_zero,
	input wire logic standby,
	input wire logic prog_busy
);
	// Program interval length, counted since it is too long to unroll
	int busy_cnt_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= prog_busy ? busy_cnt_r + 1 : 0;
	end

	// Shared clocking; stop as seen on the resolved wire
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence stop_seen;
		serial_clk && $rose(sda_in);
	endsequence

	a_drain_low: assert property (!sda_out)
		else $error("data output not low");
	a_reset_idle: assert property (
		$rose(rst_n) |-> standby && !prog_busy && sda_oe_n)
		else $error("not idle after reset");
	a_pull_clk_low: assert property (
		$fell(sda_oe_n) |-> !serial_clk) else $error("pull with clock high");
	a_hold_clk_high: assert property (
		$rose(serial_clk) |=> $stable(sda_oe_n) [*7])
		else $error("data out moved while clock high");
	a_stop_standby: assert property (
		stop_seen |-> ##[1:8] (standby || prog_busy))
		else $error("no standby or program after stop");
	a_prog_quiet: assert property (prog_busy |-> sda_oe_n && !standby)
		else $error("answer or standby during program");
	a_standby_quiet: assert property (standby |-> sda_oe_n)
		else $error("answer in standby");
	a_prog_length: assert property (
		$fell(prog_busy) |-> busy_cnt_r >= PROG_CYC - 2
			&& busy_cnt_r <= PROG_CYC + 2)
		else $error("program interval length wrong");
	a_protect_block: assert property (
		write_protect && $past(write_protect, 8) |-> !$rose(prog_busy))
		else $error("program while protected");
endmodule

bind tws_eeprom_slave tws_eeprom_slave_monitor #(.PROG_CYC(PROG_CYC))
	tws_eeprom_slave_monitor_inst (.clk(clk), .rst_n(rst_n),
	.serial_clk(serial_clk), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .write_protect(write_protect),
	.chip_select_bit_two(chip_select_bit_two),
	.chip_select_bit_one(chip_select_bit_one),
	.chip_select_bit_zero(chip_select_bit_zero), .standby(standby),
	.prog_busy(prog_busy));

// file: tb/tws_master_model.sv
`timescale 1ns/1ps

// ----------
// Bus master
// ----------
module tws_master_model (
	input  wire logic lclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	// Both lines rest released until the first frame
	initial
	begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end

	// Quarter bus period, 240 ns, well inside the low and high minimums
	task automatic qp;
		repeat (8) @(posedge lclk);
	endtask

	// Start (from high) or stop (from low); clock rests high after stop
	task automatic cond(input logic from);
		sda_drv <= from;
		qp();
		scl <= 1'h1;
		qp();
		sda_drv <= !from;
		qp();
		if (from)
			scl <= 1'h0;
		qp();
	endtask

	// One bit: data moves only with clock low, read back mid-high
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		qp();
		scl <= 1'h1;
		qp();
		r = sda;
		qp();
		scl <= 1'h0;
		qp();
	endtask

	// Eight bits MSB first, then the ninth clock
	task automatic byte_io(input logic [7:0] b, input logic ab,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r[i]);
		bit_io(ab, a);
	endtask
endmodule

// file: tb/tws_eeprom_slave_test.sv
`timescale 1ns/1ps

// ----------
// Bench
// ----------
module tws_eeprom_slave_test;
	localparam int PCYC = 2000;
	logic        clk;
	logic        lclk;
	logic        rst_n;
	logic        wp;
	logic [2:0]  cs;
	logic        scl, m_sda, sda_in, sda_out, sda_oe_n, standby, prog_busy;
	logic [7:0]  mem_m [2048];
	logic [10:0] cnt_m;
	int          fails = 0;
	int          samples_checked = 0;
	int unsigned seed = 44;

	// Open-drain wire with pull-up; two unrelated clocks
	assign sda_in = m_sda & sda_oe_n;
	always #12.5 clk = ~clk;
	always #15 lclk = ~lclk;

	tws_eeprom_slave #(.PROG_CYC(PCYC)) tws_eeprom_slave_inst (
		.clk(clk), .rst_n(rst_n), .serial_clk(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(wp),
		.chip_select_bit_two(cs[2]), .chip_select_bit_one(cs[1]),
		.chip_select_bit_zero(cs[0]), .standby(standby),
		.prog_busy(prog_busy));
	tws_master_model tws_master_model_inst (.lclk(lclk), .sda(sda_in),
		.scl(scl), .sda_drv(m_sda));

	// Helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic check(input string what, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic xfer(input logic [7:0] b, input logic ea);
		logic [7:0] r;
		logic       a;
		tws_master_model_inst.byte_io(b, 1'h1, r, a);
		check("ack", !a, ea);
	endtask

	// Write n random bytes at a; without stop it is a dummy write
	task automatic wr_page(input logic [10:0] a, input int n, input logic fin);
		logic [7:0] d;
		@(negedge clk);
		cs = 3'(rnd());
		tws_master_model_inst.cond(1'h1);
		xfer({4'ha, a[10:8], 1'h0}, 1'h1);
		xfer(a[7:0], 1'h1);
		cnt_m = a;
		for (int i = 0; i < n; i++)
		begin
			d = rnd();
			xfer(d, 1'h1);
			if (!wp)
				mem_m[cnt_m] = d;
			cnt_m[3:0] = cnt_m[3:0] + 4'h1;
		end
		if (fin)
			tws_master_model_inst.cond(1'h0);
	endtask

	// After a stop: program interval with polling, or straight to standby
	task automatic wait_prog(input logic busy);
		repeat (2) @(negedge clk);
		check("busy", prog_busy, busy);
		check("standby", standby, !busy);
		if (busy)
		begin
			tws_master_model_inst.cond(1'h1);
			xfer(8'ha0, 1'h0);
			tws_master_model_inst.cond(1'h0);
			for (int n = 0; n < 3 * PCYC && prog_busy; n++)
				@(negedge clk);
			check("done", prog_busy, 1'h0);
			if (prog_busy)
				complete_run();
			tws_master_model_inst.cond(1'h1);
			xfer(8'ha0, 1'h1);
			tws_master_model_inst.cond(1'h0);
		end
	endtask

	// Current-address read of n bytes, master acks all but the last
	task automatic rd_cur(input int n);
		logic [7:0] d;
		logic       a;
		logic [7:0] v;
		v = rnd();
		tws_master_model_inst.cond(1'h1);
		xfer({4'ha, v[2:0], 1'h1}, 1'h1);
		for (int i = 0; i < n; i++)
		begin
			tws_master_model_inst.byte_io(8'hff, i == n - 1, d, a);
			check("data", d, mem_m[cnt_m]);
			cnt_m = cnt_m + 11'h001;
		end
		tws_master_model_inst.cond(1'h0);
		repeat (2) @(negedge clk);
		check("idle", {standby, prog_busy}, 2'h2);
	endtask

	// Main sequence
	initial
	begin
		logic [3:0] nib;
		logic [7:0] v;
		// Inputs start idle; reset is asserted from time zero
		clk = 1'h0;
		lclk = 1'h0;
		rst_n = 1'h0;
		wp = 1'h0;
		cs = 3'h0;
		repeat (10) @(negedge clk);
		rst_n = 1'h1;
		repeat (4) @(negedge clk);
		check("idle", {standby, prog_busy}, 2'h2);
		for (int i = 0; i < 4; i++)
		begin
			v = rnd();
			nib = v[3:0];
			if (nib == 4'ha)
				nib = 4'h5;
			v = rnd();
			tws_master_model_inst.cond(1'h1);
			xfer({nib, v[3:0]}, 1'h0);
			tws_master_model_inst.cond(1'h0);
		end
		wr_page(11'h7f8, 17, 1'h1); // Last byte lands on slot 8, the first byte's slot
		wait_prog(1'h1);
		wr_page(11'h000, 2, 1'h1);
		wait_prog(1'h1);
		wr_page(11'h7f0, 0, 1'h0);
		rd_cur(17); // Runs off the top into address zero
		rd_cur(1);
		@(negedge clk);
		wp = 1'h1;
		wr_page(11'h7f4, 3, 1'h1);
		wait_prog(1'h0);
		@(negedge clk);
		wp = 1'h0;
		wr_page(11'h7f4, 0, 1'h0);
		rd_cur(3);
		complete_run();
	end
endmodule
